// File: phycfg_pkg.sv
package phycfg_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int          REG_ADDR_W        = 5;
  localparam int          REG_DATA_W        = 16;
  localparam logic [4:0]  ADDR_AUTONEG_EXP  = 5'h06;
  localparam logic [4:0]  ADDR_VENDOR_CFG   = 5'h10;

  // ---------------------------------------------------------------------------
  // Expansion register fields
  // ---------------------------------------------------------------------------
  localparam int EXP_PDF_BIT      = 4;
  localparam int EXP_LP_NP_BIT    = 3;
  localparam int EXP_NP_BIT       = 2;
  localparam int EXP_PAGE_RX_BIT  = 1;
  localparam int EXP_LP_AN_BIT    = 0;

  // ---------------------------------------------------------------------------
  // Configuration register fields
  // ---------------------------------------------------------------------------
  localparam int CFG_BP_CODING_BIT = 15;
  localparam int CFG_BYPASS_SCRAMBLING_BIT    = 14;
  localparam int CFG_BYPASS_SYMBOL_ALIGNMENT_BIT  = 13;
  localparam int CFG_FORCE_SD_BIT  = 12;
  localparam int CFG_RSVD11_BIT    = 11;
  localparam int CFG_TXFX_BIT      = 10;
  localparam int CFG_RSVD8_BIT     = 8;
  localparam int CFG_FLINK_BIT     = 7;
  localparam int CFG_RSVD6_BIT     = 6;
  localparam int CFG_RSVD5_BIT     = 5;
  localparam int CFG_RPD_BIT       = 4;
  localparam int CFG_STATE_MACHINE_RESET_BIT     = 3;
  localparam int CFG_PRE_SUP_BIT   = 2;
  localparam int CFG_SLEEP_BIT     = 1;
  localparam int CFG_LOOP_BIT      = 0;

  // Writable bits; bit 9 and the sequencer bits are handled apart.
  localparam logic [15:0] CFG_RW_MASK   = 16'hFDF5;
  localparam logic [15:0] CFG_RESET_VAL = 16'h0414;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int          CLK_FREQ_HZ      = 20000000;
  localparam int          SM_RESET_NS      = 1000;
  localparam int          SM_RESET_CYCLES  = (SM_RESET_NS * (CLK_FREQ_HZ / 1000000) + 999) / 1000;
  localparam int          SM_CNT_W         = 8;

  typedef enum logic [1:0] {
    PHYCFG_RUN,
    PHYCFG_SMRESET,
    PHYCFG_SLEEP
  } phycfg_state_t;
endpackage : phycfg_pkg

// File: phycfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module phycfg_regs
  import phycfg_pkg::*;
#(
  parameter int SM_RESET_LEN = SM_RESET_CYCLES
) (
  // Clock and reset
  input  wire logic                                 clk,
  input  wire logic                                 srst,
  // Register port
  input  wire logic [phycfg_pkg::REG_ADDR_W-1:0]    regAddr,
  input  wire logic [phycfg_pkg::REG_DATA_W-1:0]    regWdata,
  input  wire logic                                 regWr,
  input  wire logic                                 regRd,
  output logic      [phycfg_pkg::REG_DATA_W-1:0]    regRdata,
  // Status from the negotiation logic, asynchronous to clk
  input  wire logic                                 parallelDetectFaultIn,
  input  wire logic                                 partnerNextPageIn,
  input  wire logic                                 pageReceivedIn,
  input  wire logic                                 partnerAutonegIn,
  input  wire logic                                 lineSignalDetect,
  input  wire logic                                 lineLinkGood,
  // Controls to the datapath
  output logic                                      bypassBlockCoding,
  output logic                                      bypassScrambling,
  output logic                                      bypassSymbolAlignment,
  output logic                                      signalDetect,
  output logic                                      copperFibreSelect,
  output logic                                      linkGood100,
  output logic                                      autoReducedPowerEnable,
  output logic                                      mgmtPreambleSuppress,
  output logic                                      remoteLoopOut,
  output logic                                      stateMachineReset,
  output logic                                      sleepMode
);
  import phycfg_pkg::*;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [5:0] syncA_reg;
  logic [5:0] syncB_reg;
  logic       pageRxPrev_reg;
  logic       parallel_detect_fault;
  logic       lpNp;
  logic       pageRx;
  logic       lpAn;
  logic       sdLine;
  logic       linkLine;
  logic       pageRxEvent;

  always_ff @(posedge clk) begin
    if (srst) begin
      syncA_reg      <= 6'h00;
      syncB_reg      <= 6'h00;
      pageRxPrev_reg <= 1'b0;
    end else begin
      syncA_reg      <= {parallelDetectFaultIn, partnerNextPageIn, pageReceivedIn,
                         partnerAutonegIn, lineSignalDetect, lineLinkGood};
      syncB_reg      <= syncA_reg;
      pageRxPrev_reg <= syncB_reg[3];
    end
  end

  assign parallel_detect_fault         = syncB_reg[5];
  assign lpNp        = syncB_reg[4];
  assign pageRx      = syncB_reg[3];
  assign lpAn        = syncB_reg[2];
  assign sdLine      = syncB_reg[1];
  assign linkLine    = syncB_reg[0];
  // A new page is an edge, so one page is counted once however long it is held.
  assign pageRxEvent = pageRx & ~pageRxPrev_reg;

  // ---------------------------------------------------------------------------
  // Expansion register latches
  // ---------------------------------------------------------------------------
  logic expRead;
  logic pdfLatch_reg;
  logic pageLatch_reg;

  assign expRead = regRd && (regAddr == ADDR_AUTONEG_EXP);

  // A fault seen in the cycle of the read stays latched, so it is not lost.
  always_ff @(posedge clk) begin
    if (srst) begin
      pdfLatch_reg <= 1'b0;
    end else if (parallel_detect_fault) begin
      pdfLatch_reg <= 1'b1;
    end else if (expRead) begin
      pdfLatch_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pageLatch_reg <= 1'b0;
    end else if (pageRxEvent) begin
      pageLatch_reg <= 1'b1;
    end else if (expRead) begin
      pageLatch_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Configuration register and sequencer
  // ---------------------------------------------------------------------------
  logic [15:0]    cfg_reg;
  logic [15:0]    cfgSaved_reg;
  logic           cfgWr;
  logic           wrSleep;
  logic           wrSmrst;
  phycfg_state_t  state_reg;
  logic [SM_CNT_W-1:0] smCnt_reg;

  assign cfgWr   = regWr && (regAddr == ADDR_VENDOR_CFG);
  assign wrSleep = regWdata[CFG_SLEEP_BIT];
  assign wrSmrst = regWdata[CFG_STATE_MACHINE_RESET_BIT];

  // Sequencer: run, timed state machine reset, sleep.
  // Sleep wins over a state reset in the same write; waking starts one anyway.
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= PHYCFG_RUN;
      smCnt_reg <= '0;
    end else begin
      case (state_reg)
        PHYCFG_RUN: begin
          if (cfgWr && wrSleep) begin
            state_reg <= PHYCFG_SLEEP;
          end else if (cfgWr && wrSmrst) begin
            state_reg <= PHYCFG_SMRESET;
            smCnt_reg <= SM_CNT_W'(SM_RESET_LEN - 1);
          end
        end
        PHYCFG_SMRESET: begin
          if (smCnt_reg == '0) begin
            state_reg <= PHYCFG_RUN;
          end else begin
            smCnt_reg <= smCnt_reg - 1'b1;
          end
        end
        PHYCFG_SLEEP: begin
          if (cfgWr && !wrSleep) begin
            state_reg <= PHYCFG_SMRESET;
            smCnt_reg <= SM_CNT_W'(SM_RESET_LEN - 1);
          end
        end
        default: begin
          state_reg <= PHYCFG_RUN;
        end
      endcase
    end
  end

  // While asleep only the sleep bit is honoured; waking restores the image
  // saved on entry, though during sleep the datapath controls follow the sleep write.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_reg <= CFG_RESET_VAL;
    end else if (cfgWr && state_reg != PHYCFG_SLEEP) begin
      cfg_reg <= (regWdata & CFG_RW_MASK) & ~(16'h0001 << CFG_SLEEP_BIT);
      if (wrSleep) begin
        cfg_reg[CFG_SLEEP_BIT] <= 1'b1;
      end
    end else if (cfgWr && !wrSleep) begin
      cfg_reg <= cfgSaved_reg;
    end
  end

  // The image is taken before the sleep write lands, so waking brings back
  // the settings in force just before sleep.
  always_ff @(posedge clk) begin
    if (srst) begin
      cfgSaved_reg <= CFG_RESET_VAL;
    end else if (cfgWr && wrSleep && state_reg != PHYCFG_SLEEP) begin
      cfgSaved_reg <= cfg_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------------------
  logic [15:0] expValue;
  logic [15:0] cfgValue;

  // Bits 3 and 0 are live views of the partner; bits 4 and 1 are latched.
  always_comb begin
    expValue                  = 16'h0000;
    expValue[EXP_PDF_BIT]     = pdfLatch_reg;
    expValue[EXP_LP_NP_BIT]   = lpNp;
    expValue[EXP_NP_BIT]      = 1'b0;
    expValue[EXP_PAGE_RX_BIT] = pageLatch_reg;
    expValue[EXP_LP_AN_BIT]   = lpAn;
    cfgValue                  = cfg_reg;
    cfgValue[CFG_STATE_MACHINE_RESET_BIT]   = (state_reg == PHYCFG_SMRESET);
    cfgValue[CFG_SLEEP_BIT]   = (state_reg == PHYCFG_SLEEP);
  end

  // Read data is zero outside the answer cycle, so a stale word is never
  // mistaken for a reply.
  always_ff @(posedge clk) begin
    if (srst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        ADDR_AUTONEG_EXP: regRdata <= expValue;
        ADDR_VENDOR_CFG:  regRdata <= cfgValue;
        default:          regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // ---------------------------------------------------------------------------
  // Datapath controls: coding, scrambling and alignment bypass
  // ---------------------------------------------------------------------------
  // Bit 13 bypasses every stage that bits 15 and 14 cover, so it feeds both.
  always_ff @(posedge clk) begin
    if (srst) begin
      bypassBlockCoding <= CFG_RESET_VAL[CFG_BP_CODING_BIT];
    end else begin
      bypassBlockCoding <= cfg_reg[CFG_BP_CODING_BIT] | cfg_reg[CFG_BYPASS_SYMBOL_ALIGNMENT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bypassScrambling <= CFG_RESET_VAL[CFG_BYPASS_SCRAMBLING_BIT];
    end else begin
      bypassScrambling <= cfg_reg[CFG_BYPASS_SCRAMBLING_BIT] | cfg_reg[CFG_BYPASS_SYMBOL_ALIGNMENT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bypassSymbolAlignment <= CFG_RESET_VAL[CFG_BYPASS_SYMBOL_ALIGNMENT_BIT];
    end else begin
      bypassSymbolAlignment <= cfg_reg[CFG_BYPASS_SYMBOL_ALIGNMENT_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Datapath controls: line status overrides
  // ---------------------------------------------------------------------------
  // Forcing only adds a good status; a real line indication still gets through.
  always_ff @(posedge clk) begin
    if (srst) begin
      signalDetect <= CFG_RESET_VAL[CFG_FORCE_SD_BIT];
    end else begin
      signalDetect <= sdLine | cfg_reg[CFG_FORCE_SD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      linkGood100 <= CFG_RESET_VAL[CFG_FLINK_BIT];
    end else begin
      linkGood100 <= linkLine | cfg_reg[CFG_FLINK_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Datapath controls: operating modes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      copperFibreSelect <= CFG_RESET_VAL[CFG_TXFX_BIT];
    end else begin
      copperFibreSelect <= cfg_reg[CFG_TXFX_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      autoReducedPowerEnable <= CFG_RESET_VAL[CFG_RPD_BIT];
    end else begin
      autoReducedPowerEnable <= cfg_reg[CFG_RPD_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mgmtPreambleSuppress <= CFG_RESET_VAL[CFG_PRE_SUP_BIT];
    end else begin
      mgmtPreambleSuppress <= cfg_reg[CFG_PRE_SUP_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      remoteLoopOut <= CFG_RESET_VAL[CFG_LOOP_BIT];
    end else begin
      remoteLoopOut <= cfg_reg[CFG_LOOP_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer status
  // ---------------------------------------------------------------------------
  // Registered copies of the state, so the outputs never glitch on decoding.
  always_ff @(posedge clk) begin
    if (srst) begin
      stateMachineReset <= 1'b0;
    end else begin
      stateMachineReset <= (state_reg == PHYCFG_SMRESET);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sleepMode <= 1'b0;
    end else begin
      sleepMode <= (state_reg == PHYCFG_SLEEP);
    end
  end

endmodule // phycfg_regs
`default_nettype wire

// File: phycfg_neg_model.sv
`timescale 1ns/1ps
`default_nettype none
module phycfg_neg_model (
  // Commanded status and the lines it drives
  input  wire logic       clk,
  input  wire logic [5:0] cmd,
  output var  logic [5:0] lines
);
  // Status moves on a rising edge, registered from the command.
  always_ff @(posedge clk) begin
    lines <= cmd;
  end
endmodule // phycfg_neg_model
`default_nettype wire

// File: phycfg_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module phycfg_regs_props
  import phycfg_pkg::*;
#(parameter int SM_RESET_LEN = 3) (
  // Clock, reset and register port
  input wire logic                  clk, srst, regWr, regRd,
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [REG_DATA_W-1:0] regWdata, regRdata,
  // Status and controls
  input wire logic parallelDetectFaultIn, partnerNextPageIn, pageReceivedIn,
  input wire logic partnerAutonegIn, lineSignalDetect, lineLinkGood,
  input wire logic bypassBlockCoding, bypassScrambling, bypassSymbolAlignment,
  input wire logic signalDetect, copperFibreSelect, linkGood100,
  input wire logic autoReducedPowerEnable, mgmtPreambleSuppress, remoteLoopOut,
  input wire logic stateMachineReset, sleepMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic       rdCfg_reg, rdExp_reg, cfgWr;
  logic [7:0] smCnt_reg;
  assign cfgWr = regWr && regAddr == ADDR_VENDOR_CFG && !sleepMode && !regWdata[1];
  always_ff @(posedge clk) begin
    rdCfg_reg <= regRd && regAddr == ADDR_VENDOR_CFG;
    rdExp_reg <= regRd && regAddr == ADDR_AUTONEG_EXP;
  end
  // Counts how long the timed state reset stays up.
  always_ff @(posedge clk) begin
    smCnt_reg <= (srst || !stateMachineReset) ? 8'h00 : smCnt_reg + 8'h01;
  end
  exp_rsvd_a: assert property (rdExp_reg |-> regRdata[15:5] == 11'h000 && !regRdata[2])
    else $error("expansion reserved bits not zero");
  loop_follow_a: assert property (cfgWr |-> ##2 remoteLoopOut == $past(regWdata[0], 2))
    else $error("loop out does not follow write");
  bypass_follow_a: assert property (cfgWr |-> ##2
    bypassScrambling == ($past(regWdata[14], 2) || $past(regWdata[13], 2)))
    else $error("scrambler bypass does not follow write");
  force_sd_a: assert property (rdCfg_reg && regRdata[12] |-> signalDetect)
    else $error("forced signal detect not active");
  force_link_a: assert property (rdCfg_reg && regRdata[7] |-> linkGood100)
    else $error("forced link not good");
  static_cfg_a: assert property (rdCfg_reg && !sleepMode |->
    {copperFibreSelect, autoReducedPowerEnable, mgmtPreambleSuppress}
    == {regRdata[10], regRdata[4], regRdata[2]})
    else $error("mode outputs differ from register");
  state_machine_reset_len_a: assert property ($fell(stateMachineReset) |-> smCnt_reg == SM_RESET_LEN)
    else $error("state reset length wrong");
  sleep_enter_a: assert property (regWr && regAddr == ADDR_VENDOR_CFG && regWdata[1]
    |-> ##2 sleepMode)
    else $error("sleep not entered");
endmodule // phycfg_regs_props
bind phycfg_regs phycfg_regs_props #(.SM_RESET_LEN(SM_RESET_LEN)) i_props (.*);
`default_nettype wire

// File: phycfg_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module phycfg_regs_tb;
  import phycfg_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic [4:0]  regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000, regRdata, mdl, v, d;
  logic [5:0]  cmd = 6'h00, lines;
  logic [10:0] ctl;
  logic [31:0] seed = 32'h00012F1A;
  int          n_fail = 0, checks = 0, i;
  always #25 clk = ~clk;
  phycfg_neg_model i_neg (.clk(clk), .cmd(cmd), .lines(lines));
  phycfg_regs #(.SM_RESET_LEN(3)) i_dut (.clk(clk), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .parallelDetectFaultIn(lines[5]), .partnerNextPageIn(lines[4]),
    .pageReceivedIn(lines[3]), .partnerAutonegIn(lines[2]),
    .lineSignalDetect(lines[1]), .lineLinkGood(lines[0]),
    .bypassBlockCoding(ctl[10]), .bypassScrambling(ctl[9]), .bypassSymbolAlignment(ctl[8]),
    .signalDetect(ctl[7]), .copperFibreSelect(ctl[6]), .linkGood100(ctl[5]),
    .autoReducedPowerEnable(ctl[4]), .mgmtPreambleSuppress(ctl[3]),
    .remoteLoopOut(ctl[2]), .stateMachineReset(ctl[1]), .sleepMode(ctl[0]));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [10:0] ectl(input logic [15:0] m, input logic s, l, z);
    return {m[15] | m[13], m[14] | m[13], m[13], m[12] | s, m[10], m[7] | l,
            m[4], m[2], m[0], 1'b0, z};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] dd);
    @(posedge clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= dd;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge clk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 q = regRdata;
  endtask
  task automatic lets(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++; $display("BAD %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic cmpc(input logic [10:0] e);
    checks++;
    if (ctl !== e) begin
      n_fail++; $display("BAD %0t controls %h want %h", $time, ctl, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Waits out a timed state reset, giving up after a bounded time.
  task automatic waitsm;
    int k;
    k = 0;
    while (ctl[1] !== 1'b0 && k < 50) begin
      lets(1); k++;
    end
    if (k == 50) begin
      n_fail++; $display("BAD %0t state reset stuck", $time); give_verdict();
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    mdl = 16'h0414;
    lets(1); cmpc(ectl(mdl, 1'b0, 1'b0, 1'b0));
    rd(ADDR_VENDOR_CFG, v); cmp(mdl, v);
    wr(ADDR_AUTONEG_EXP, 16'hFFFF);
    rd(ADDR_AUTONEG_EXP, v); cmp(16'h0000, v);
    rd(5'h1F, v); cmp(16'h0000, v);
    for (i = 0; i < 8; i++) begin
      seed = nxt(seed);
      cmd <= {4'h0, seed[17:16]};
      d = seed[15:0] & 16'hF695;
      mdl = d & 16'hF495;
      wr(ADDR_VENDOR_CFG, d);
      lets(3); cmpc(ectl(mdl, seed[17], seed[16], 1'b0));
      rd(ADDR_VENDOR_CFG, v); cmp(mdl, v);
    end
    cmd <= 6'h3C;
    lets(4);
    cmd <= 6'h14;
    lets(4);
    rd(ADDR_AUTONEG_EXP, v); cmp(16'h001B, v);
    rd(ADDR_AUTONEG_EXP, v); cmp(16'h0009, v);
    cmd <= 6'h00;
    lets(4);
    rd(ADDR_AUTONEG_EXP, v); cmp(16'h0000, v);
    wr(ADDR_VENDOR_CFG, mdl | 16'h0008);
    lets(1); cmpc(ectl(mdl, 1'b0, 1'b0, 1'b0) | 11'h002);
    rd(ADDR_VENDOR_CFG, v); cmp(mdl | 16'h0008, v);
    waitsm();
    rd(ADDR_VENDOR_CFG, v); cmp(mdl, v);
    wr(ADDR_VENDOR_CFG, mdl | 16'h0002);
    lets(1); cmpc(ectl(mdl, 1'b0, 1'b0, 1'b1));
    wr(ADDR_VENDOR_CFG, 16'h0002);
    rd(ADDR_VENDOR_CFG, v); cmp(mdl | 16'h0002, v);
    wr(ADDR_VENDOR_CFG, ~mdl & 16'hF495);
    lets(1); cmpc(ectl(mdl, 1'b0, 1'b0, 1'b0) | 11'h002);
    waitsm();
    cmpc(ectl(mdl, 1'b0, 1'b0, 1'b0));
    rd(ADDR_VENDOR_CFG, v); cmp(mdl, v);
    give_verdict();
  end
endmodule // phycfg_regs_tb
`default_nettype wire
